// ==== core/dpcc_pkg.sv ====
package dpcc_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CLK_POL = 10'h09d;
    localparam logic [9:0] IDX_TEST_OUT = 10'h0a0;
    localparam logic [9:0] IDX_LANE_INTERP = 10'h110;
    localparam logic [9:0] IDX_DP_OPT = 10'h111;
    localparam logic [9:0] IDX_TW_UPD = 10'h113;
    localparam logic [9:0] IDX_TW_BYTE0 = 10'h114;
    localparam int TW_BYTES = 6;
    // decoded register selects
    localparam logic [3:0] SEL_CLK_POL = 4'h0;
    localparam logic [3:0] SEL_TEST_OUT = 4'h1;
    localparam logic [3:0] SEL_LANE_INTERP = 4'h2;
    localparam logic [3:0] SEL_DP_OPT = 4'h3;
    localparam logic [3:0] SEL_TW_UPD = 4'h4;
    localparam logic [3:0] SEL_TW0 = 4'h5;
    localparam logic [3:0] SEL_NONE = 4'hf;
    // field positions
    localparam int POS_INV_CLK = 2;
    localparam int POS_DUTY = 1;
    localparam int POS_XCTL = 0;
    localparam int POS_TEST_EN = 7;
    localparam int POS_LANES = 4;
    localparam int POS_SINC = 7;
    localparam int POS_MOD_EN = 6;
    localparam int POS_BW = 4;
    localparam int POS_MODULUS = 2;
    localparam int POS_SIDEBAND = 1;
    localparam int POS_FIR = 0;
    localparam int POS_REQ_MODE = 4;
    localparam int POS_SYNC_LOAD = 2;
    localparam int POS_ACK = 1;
    localparam int POS_REQ = 0;
    // reset values and request mode limits
    localparam logic RST_INV_CLK = 1'h0;
    localparam logic RST_DUTY = 1'h1;
    localparam logic RST_XCTL = 1'h1;
    localparam logic [3:0] RST_LANES = 4'h8;
    localparam logic [3:0] RST_INTERP = 4'h1;
    localparam logic RST_SINC = 1'h0;
    localparam logic [2:0] MODE_NONE = 3'h0;
    localparam logic [2:0] MODE_LAST = 3'h6;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dpcc_pkg

// ==== core/dpcc_regs.sv ====
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - polarity bit inverts the derived logic clock
// - duty correction enable, resets to one
// - clock cross control enable, resets to one
// - test enable gates divided loop clock out
// - lane count from upper nibble, resets eight
// - interpolation factor low nibble, resets bypass
// - sinc compensation filter bit, resets bypassed
// - bandwidth bit selects 80 or 90 percent
// - sideband bit selects upper or lower
// - mode zero makes no automatic load request
// - modes one to six load after their chosen byte; mode seven makes no request
// - mode six loads after most significant byte
// - request rising edge loads, sets acknowledge
module dpcc_regs (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // axi4-lite write address and data
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    // axi4-lite write response
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // axi4-lite read
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [31:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // clock configuration
    output logic invert_logic_clock_out,
    output logic clock_duty_correct_en_out,
    output logic clock_cross_control_en_out,
    output logic loop_test_clk_out,
    // datapath configuration
    output logic [3:0] link_lane_count_out,
    output logic [3:0] lanes_and_interpolation_out,
    output logic sinc_comp_filter_en_out,
    output logic modulation_en_out,
    output logic filter_bandwidth_sel_out,
    output logic modulus_en_out,
    output logic sideband_sel_out,
    output logic extra_fir_en_out,
    // tuning word to the oscillator
    output logic [47:0] tuning_word_out,
    output logic tuning_load_strobe_out,
    output logic tuning_load_on_sync_out
);
    typedef struct packed {
        logic aw_got;
        logic [31:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_strb0, bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic inv_clk, duty, xctl, test_en;
        logic [1:0] test_div;
        logic [2:0] div_cnt;
        logic test_clk;
        logic [3:0] lanes;
        logic [3:0] interp;
        logic sinc, mod_en, bw, modulus, sideband, fir;
        logic [2:0] req_mode;
        logic sync_load, ack, req;
        logic [47:0] stage;
        logic [47:0] tword;
        logic strobe;
    } dpcc_state_t;

    dpcc_state_t state_ff;
    dpcc_state_t nxt_state;

    logic wr_fire;
    logic [3:0] wr_sel;
    logic [7:0] wr_byte;

    function automatic logic [3:0] dpcc_decode(input logic [31:0] addr);
        logic [9:0] idx;
        logic [3:0] sel;
        idx = addr[11:2];
        unique case (idx)
            dpcc_pkg::IDX_CLK_POL: sel = dpcc_pkg::SEL_CLK_POL;
            dpcc_pkg::IDX_TEST_OUT: sel = dpcc_pkg::SEL_TEST_OUT;
            dpcc_pkg::IDX_LANE_INTERP: sel = dpcc_pkg::SEL_LANE_INTERP;
            dpcc_pkg::IDX_DP_OPT: sel = dpcc_pkg::SEL_DP_OPT;
            dpcc_pkg::IDX_TW_UPD: sel = dpcc_pkg::SEL_TW_UPD;
            default: sel = dpcc_pkg::SEL_NONE;
        endcase
        if (idx >= dpcc_pkg::IDX_TW_BYTE0 &&
            idx < dpcc_pkg::IDX_TW_BYTE0 + 10'(dpcc_pkg::TW_BYTES)) begin
            sel = dpcc_pkg::SEL_TW0 + 4'(idx - dpcc_pkg::IDX_TW_BYTE0);
        end
        if (addr[31:12] != 20'h00000) begin
            sel = dpcc_pkg::SEL_NONE;
        end
        return sel;
    endfunction : dpcc_decode

    assign s_axi_awready_out = !state_ff.aw_got && !state_ff.bvalid;
    assign s_axi_wready_out = !state_ff.w_got && !state_ff.bvalid;
    assign s_axi_arready_out = !state_ff.rvalid;

    always_comb begin
        logic aw_now, w_now;
        logic [31:0] addr;
        logic strb0;
        logic [3:0] rsel;
        logic [7:0] rd;
        logic [3:0] tsel;
        tsel = 4'h0;
        rsel = dpcc_decode(s_axi_araddr_in);
        rd = 8'h00;
        aw_now = s_axi_awvalid_in && s_axi_awready_out;
        w_now = s_axi_wvalid_in && s_axi_wready_out;
        addr = state_ff.aw_got ? state_ff.aw_addr : s_axi_awaddr_in;
        strb0 = state_ff.w_got ? state_ff.w_strb0 : s_axi_wstrb_in[0];
        wr_byte = state_ff.w_got ? state_ff.w_data : s_axi_wdata_in[7:0];
        wr_sel = dpcc_decode(addr);
        nxt_state = state_ff;
        nxt_state.strobe = 1'b0;
        wr_fire = 1'b0;
        if (aw_now) begin
            nxt_state.aw_got = 1'b1;
            nxt_state.aw_addr = s_axi_awaddr_in;
        end
        if (w_now) begin
            nxt_state.w_got = 1'b1;
            nxt_state.w_data = s_axi_wdata_in[7:0];
            nxt_state.w_strb0 = s_axi_wstrb_in[0];
        end
        // write completes once address and data are both in hand
        if ((state_ff.aw_got || aw_now) && (state_ff.w_got || w_now)) begin
            nxt_state.aw_got = 1'b0;
            nxt_state.w_got = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = (wr_sel == dpcc_pkg::SEL_NONE) ?
                dpcc_pkg::RESP_SLVERR : dpcc_pkg::RESP_OKAY;
            wr_fire = strb0 && (wr_sel != dpcc_pkg::SEL_NONE);
        end
        if (state_ff.bvalid && s_axi_bready_in) begin
            nxt_state.bvalid = 1'b0;
        end
        // reserved positions are never stored
        if (wr_fire) begin
            unique case (wr_sel)
                dpcc_pkg::SEL_CLK_POL: begin
                    nxt_state.inv_clk = wr_byte[dpcc_pkg::POS_INV_CLK];
                    nxt_state.duty = wr_byte[dpcc_pkg::POS_DUTY];
                    nxt_state.xctl = wr_byte[dpcc_pkg::POS_XCTL];
                end
                dpcc_pkg::SEL_TEST_OUT: begin
                    nxt_state.test_en = wr_byte[dpcc_pkg::POS_TEST_EN];
                    nxt_state.test_div = wr_byte[1:0];
                end
                dpcc_pkg::SEL_LANE_INTERP: begin
                    nxt_state.lanes = wr_byte[dpcc_pkg::POS_LANES +: 4];
                    nxt_state.interp = wr_byte[3:0];
                end
                dpcc_pkg::SEL_DP_OPT: begin
                    nxt_state.sinc = wr_byte[dpcc_pkg::POS_SINC];
                    nxt_state.mod_en = wr_byte[dpcc_pkg::POS_MOD_EN];
                    nxt_state.bw = wr_byte[dpcc_pkg::POS_BW];
                    nxt_state.modulus = wr_byte[dpcc_pkg::POS_MODULUS];
                    nxt_state.sideband = wr_byte[dpcc_pkg::POS_SIDEBAND];
                    nxt_state.fir = wr_byte[dpcc_pkg::POS_FIR];
                end
                dpcc_pkg::SEL_TW_UPD: begin
                    nxt_state.req_mode = wr_byte[dpcc_pkg::POS_REQ_MODE +: 3];
                    nxt_state.sync_load = wr_byte[dpcc_pkg::POS_SYNC_LOAD];
                    nxt_state.req = wr_byte[dpcc_pkg::POS_REQ];
                    if (!wr_byte[dpcc_pkg::POS_REQ]) begin
                        nxt_state.ack = 1'b0;
                    end else if (!state_ff.req) begin
                        nxt_state.tword = state_ff.stage;
                        nxt_state.ack = 1'b1;
                        nxt_state.strobe = 1'b1;
                    end
                end
                default: begin
                    tsel = wr_sel - dpcc_pkg::SEL_TW0;
                    nxt_state.stage[8 * tsel[2:0] +: 8] = wr_byte;
                    // mode n picks byte n-1; mode zero never requests
                    if (state_ff.req_mode != dpcc_pkg::MODE_NONE &&
                        state_ff.req_mode <= dpcc_pkg::MODE_LAST &&
                        tsel[2:0] == state_ff.req_mode - 3'h1) begin
                        nxt_state.tword = nxt_state.stage;
                        nxt_state.req = 1'b1;
                        nxt_state.ack = 1'b1;
                        nxt_state.strobe = 1'b1;
                    end
                end
            endcase
        end
        // read path
        unique case (rsel)
            dpcc_pkg::SEL_CLK_POL: begin
                rd = {5'h00, state_ff.inv_clk, state_ff.duty,
                    state_ff.xctl};
            end
            dpcc_pkg::SEL_TEST_OUT: begin
                rd = {state_ff.test_en, 5'h00, state_ff.test_div};
            end
            dpcc_pkg::SEL_LANE_INTERP: rd = {state_ff.lanes, state_ff.interp};
            dpcc_pkg::SEL_DP_OPT: begin
                rd = {state_ff.sinc, state_ff.mod_en, 1'b0, state_ff.bw, 1'b0,
                    state_ff.modulus, state_ff.sideband, state_ff.fir};
            end
            dpcc_pkg::SEL_TW_UPD: begin
                rd = {1'b0, state_ff.req_mode, 1'b0, state_ff.sync_load,
                    state_ff.ack, state_ff.req};
            end
            dpcc_pkg::SEL_NONE: rd = 8'h00;
            default: begin
                tsel = rsel - dpcc_pkg::SEL_TW0;
                rd = state_ff.stage[8 * tsel[2:0] +: 8];
            end
        endcase
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rdata = rd;
            nxt_state.rresp = (rsel == dpcc_pkg::SEL_NONE) ?
                dpcc_pkg::RESP_SLVERR : dpcc_pkg::RESP_OKAY;
        end
        if (state_ff.rvalid && s_axi_rready_in) begin
            nxt_state.rvalid = 1'b0;
        end
        // test clock toggles every 2^div cycles, held low when disabled
        nxt_state.div_cnt = state_ff.div_cnt + 3'h1;
        if (state_ff.div_cnt >= (3'h7 >> (2'h3 - state_ff.test_div))) begin
            nxt_state.div_cnt = 3'h0;
            nxt_state.test_clk = !state_ff.test_clk;
        end
        if (!state_ff.test_en) begin
            nxt_state.test_clk = 1'b0;
            nxt_state.div_cnt = 3'h0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_ff <= '0;
            state_ff.inv_clk <= dpcc_pkg::RST_INV_CLK;
            state_ff.duty <= dpcc_pkg::RST_DUTY;
            state_ff.xctl <= dpcc_pkg::RST_XCTL;
            state_ff.lanes <= dpcc_pkg::RST_LANES;
            state_ff.interp <= dpcc_pkg::RST_INTERP;
            state_ff.sinc <= dpcc_pkg::RST_SINC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign s_axi_bvalid_out = state_ff.bvalid;
    assign s_axi_bresp_out = state_ff.bresp;
    assign s_axi_rvalid_out = state_ff.rvalid;
    assign s_axi_rdata_out = {24'h000000, state_ff.rdata};
    assign s_axi_rresp_out = state_ff.rresp;
    assign invert_logic_clock_out = state_ff.inv_clk;
    assign clock_duty_correct_en_out = state_ff.duty;
    assign clock_cross_control_en_out = state_ff.xctl;
    assign loop_test_clk_out = state_ff.test_clk;
    assign link_lane_count_out = state_ff.lanes;
    assign lanes_and_interpolation_out = state_ff.interp;
    assign sinc_comp_filter_en_out = state_ff.sinc;
    assign modulation_en_out = state_ff.mod_en;
    assign filter_bandwidth_sel_out = state_ff.bw;
    assign modulus_en_out = state_ff.modulus;
    assign sideband_sel_out = state_ff.sideband;
    assign extra_fir_en_out = state_ff.fir;
    assign tuning_word_out = state_ff.tword;
    assign tuning_load_strobe_out = state_ff.strobe;
    assign tuning_load_on_sync_out = state_ff.sync_load;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence seq_req_rise;
        wr_fire && wr_sel == dpcc_pkg::SEL_TW_UPD && wr_byte[0] &&
            !state_ff.req;
    endsequence
    sequence seq_loaded;
        tuning_load_strobe_out && state_ff.ack;
    endsequence

    a_reset_values: assert property ($fell(sys_rst_in) |->
        clock_duty_correct_en_out && clock_cross_control_en_out &&
        !invert_logic_clock_out && !sinc_comp_filter_en_out &&
        link_lane_count_out == 4'h8 && lanes_and_interpolation_out == 4'h1)
        else $error("reset values wrong");
    a_pol_write: assert property (wr_fire && wr_sel == 4'h0 |=>
        invert_logic_clock_out == $past(wr_byte[2]))
        else $error("polarity bit not taken");
    a_test_gate: assert property (!state_ff.test_en |=>
        !loop_test_clk_out)
        else $error("test clock runs while disabled");
    a_lane_write: assert property (wr_fire && wr_sel == 4'h2 |=>
        link_lane_count_out == $past(wr_byte[7:4]) &&
        lanes_and_interpolation_out == $past(wr_byte[3:0]))
        else $error("lane or interpolation not taken");
    a_dp_opts: assert property (wr_fire && wr_sel == 4'h3 |=>
        sinc_comp_filter_en_out == $past(wr_byte[7]) &&
        filter_bandwidth_sel_out == $past(wr_byte[4]) &&
        sideband_sel_out == $past(wr_byte[1]))
        else $error("datapath option not taken");
    a_no_auto_load: assert property (wr_fire && wr_sel >= 4'h5 &&
        state_ff.req_mode == 3'h0 |=> !tuning_load_strobe_out)
        else $error("load without automatic mode");
    a_auto_load: assert property (wr_fire && wr_sel >= 4'h5 &&
        state_ff.req_mode != 3'h0 && state_ff.req_mode != 3'h7 &&
        wr_sel - 4'h5 == {1'b0, state_ff.req_mode} - 4'h1 |=> seq_loaded)
        else $error("automatic load missing");
    a_req_load: assert property (seq_req_rise |=> seq_loaded ##0
        tuning_word_out == $past(state_ff.stage))
        else $error("request edge did not load");
    a_ack_clear: assert property (wr_fire && wr_sel == 4'h4 &&
        !wr_byte[0] |=> !state_ff.ack)
        else $error("acknowledge not cleared");
    a_read_zero: assert property (s_axi_arvalid_in && s_axi_arready_out &&
        dpcc_decode(s_axi_araddr_in) == dpcc_pkg::SEL_DP_OPT |=>
        s_axi_rdata_out[5] == 1'b0 && s_axi_rdata_out[3] == 1'b0)
        else $error("reserved read bits not zero");
endmodule : dpcc_regs

// ==== tb/datapath_clock_config_regs_tb_top.sv ====
`timescale 1ns/1ps
module datapath_clock_config_regs_tb_top;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic inv_clk, duty, xctl, test_clk, sinc, mod_en, bw, modulus, sideband;
    logic fir, tw_strobe, tw_sync;
    logic [3:0] lanes, interp;
    logic [47:0] tw;
    logic [5:0] dp_outs;
    logic [7:0] stg [6];
    int miscompares = 0;
    int n_checks = 0;
    int n_strobe = 0;

    always #10 mclk_in = ~mclk_in;

    assign dp_outs = {sinc, mod_en, bw, modulus, sideband, fir};

    always @(posedge mclk_in) begin
        if (tw_strobe === 1'b1) n_strobe++;
    end

    dpcc_regs DUT (
        .mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .invert_logic_clock_out(inv_clk),
        .clock_duty_correct_en_out(duty),
        .clock_cross_control_en_out(xctl), .loop_test_clk_out(test_clk),
        .link_lane_count_out(lanes), .lanes_and_interpolation_out(interp),
        .sinc_comp_filter_en_out(sinc), .modulation_en_out(mod_en),
        .filter_bandwidth_sel_out(bw), .modulus_en_out(modulus),
        .sideband_sel_out(sideband), .extra_fir_en_out(fir),
        .tuning_word_out(tw), .tuning_load_strobe_out(tw_strobe),
        .tuning_load_on_sync_out(tw_sync)
    );

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [47:0] e,
                       input logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    function automatic logic [31:0] adr(input logic [9:0] idx);
        return {20'h0, idx, 2'h0};
    endfunction : adr

    function automatic logic [47:0] staged();
        return {stg[5], stg[4], stg[3], stg[2], stg[1], stg[0]};
    endfunction : staged

    task automatic wr(input logic [31:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        int i;
        logic [1:0] r;
        r = 2'h3;
        @(posedge mclk_in);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        // upper data bits set to show they are ignored
        wdata <= {24'hffffff, d};
        wstrb <= s;
        bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge mclk_in);
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end
        chk("bresp", er, r);
        if (i == 64) end_of_test();
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [7:0] ed,
                      input logic [1:0] er);
        int i;
        logic [31:0] d;
        logic [1:0] r;
        d = 32'hx;
        r = 2'h3;
        @(posedge mclk_in);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge mclk_in);
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end
        chk("rdata", {24'h0, ed}, d);
        chk("rresp", er, r);
        if (i == 64) end_of_test();
    endtask : rd

    task automatic wr_ok(input logic [9:0] idx, input logic [7:0] d);
        wr(adr(idx), d, 4'h1, dpcc_pkg::RESP_OKAY);
    endtask : wr_ok

    task automatic rd_ok(input logic [9:0] idx, input logic [7:0] d);
        rd(adr(idx), d, dpcc_pkg::RESP_OKAY);
    endtask : rd_ok

    task automatic t_reset_vals;
        chk("reset outs", 3'b011, {inv_clk, duty, xctl});
        chk("reset lanes", 8'h81, {lanes, interp});
        chk("reset sinc", 1'b0, sinc);
        rd_ok(dpcc_pkg::IDX_CLK_POL, 8'h03);
        rd_ok(dpcc_pkg::IDX_TEST_OUT, 8'h00);
        rd_ok(dpcc_pkg::IDX_LANE_INTERP, 8'h81);
        rd_ok(dpcc_pkg::IDX_DP_OPT, 8'h00);
        rd_ok(dpcc_pkg::IDX_TW_UPD, 8'h00);
    endtask : t_reset_vals

    task automatic t_clock_regs;
        wr_ok(dpcc_pkg::IDX_CLK_POL, 8'hfc);
        chk("clk outs", 3'b100, {inv_clk, duty, xctl});
        rd_ok(dpcc_pkg::IDX_CLK_POL, 8'h04);
        wr_ok(dpcc_pkg::IDX_CLK_POL, 8'h03);
        chk("clk outs", 3'b011, {inv_clk, duty, xctl});
    endtask : t_clock_regs

    task automatic t_test_out;
        int n, k, c;
        logic p;
        wr_ok(dpcc_pkg::IDX_TEST_OUT, 8'h7f);
        rd_ok(dpcc_pkg::IDX_TEST_OUT, 8'h03);
        c = 0;
        for (k = 0; k < 16; k++) begin
            @(posedge mclk_in);
            if (test_clk !== 1'b0) c++;
        end
        chk("test clk idle", 0, c);
        for (n = 0; n < 4; n++) begin
            wr_ok(dpcc_pkg::IDX_TEST_OUT, 8'h80 | 8'(n));
            rd_ok(dpcc_pkg::IDX_TEST_OUT, 8'h80 | 8'(n));
            p = test_clk;
            c = 0;
            for (k = 0; k < 32; k++) begin
                @(posedge mclk_in);
                if (test_clk !== p) c++;
                p = test_clk;
            end
            chk("test clk toggles", 32 >> n, c);
        end
        wr_ok(dpcc_pkg::IDX_TEST_OUT, 8'h00);
        repeat (2) @(posedge mclk_in);
        chk("test clk off", 1'b0, test_clk);
    endtask : t_test_out

    task automatic t_lane_interp;
        wr_ok(dpcc_pkg::IDX_LANE_INTERP, 8'h48);
        chk("lanes interp", 8'h48, {lanes, interp});
        rd_ok(dpcc_pkg::IDX_LANE_INTERP, 8'h48);
        wr_ok(dpcc_pkg::IDX_LANE_INTERP, 8'h81);
        chk("lanes interp", 8'h81, {lanes, interp});
    endtask : t_lane_interp

    task automatic t_datapath;
        wr_ok(dpcc_pkg::IDX_DP_OPT, 8'hff);
        chk("dp outs", 6'h3f, dp_outs);
        rd_ok(dpcc_pkg::IDX_DP_OPT, 8'hd7);
        wr_ok(dpcc_pkg::IDX_DP_OPT, 8'h12);
        chk("dp outs", 6'h0a, dp_outs);
    endtask : t_datapath

    task automatic t_tw_manual;
        int i, s;
        for (i = 0; i < 6; i++) begin
            stg[i] = 8'(8'h11 * (i + 1));
            wr_ok(dpcc_pkg::IDX_TW_BYTE0 + 10'(i), stg[i]);
        end
        repeat (2) @(posedge mclk_in);
        chk("no auto strobe", 0, n_strobe);
        chk("word held", 48'h0, tw);
        wr_ok(dpcc_pkg::IDX_TW_UPD, 8'h01);
        repeat (2) @(posedge mclk_in);
        chk("manual strobe", 1, n_strobe);
        chk("manual word", staged(), tw);
        rd_ok(dpcc_pkg::IDX_TW_UPD, 8'h03);
        s = n_strobe;
        wr_ok(dpcc_pkg::IDX_TW_UPD, 8'h01);
        repeat (2) @(posedge mclk_in);
        chk("no repeat load", s, n_strobe);
        wr_ok(dpcc_pkg::IDX_TW_UPD, 8'h8c);
        chk("sync bit", 1'b1, tw_sync);
        rd_ok(dpcc_pkg::IDX_TW_UPD, 8'h04);
        wr_ok(dpcc_pkg::IDX_TW_UPD, 8'h00);
    endtask : t_tw_manual

    task automatic t_tw_auto;
        int m, s, o;
        for (m = 1; m <= 7; m++) begin
            wr_ok(dpcc_pkg::IDX_TW_UPD, 8'(m << 4));
            rd_ok(dpcc_pkg::IDX_TW_UPD, 8'(m << 4));
            o = m % 6;
            s = n_strobe;
            stg[o] = 8'(8'h30 + m);
            wr_ok(dpcc_pkg::IDX_TW_BYTE0 + 10'(o), stg[o]);
            repeat (2) @(posedge mclk_in);
            chk("other byte", s, n_strobe);
            stg[(m + 5) % 6] = 8'(8'ha0 + m);
            wr_ok(dpcc_pkg::IDX_TW_BYTE0 + 10'((m + 5) % 6), stg[(m + 5) % 6]);
            repeat (2) @(posedge mclk_in);
            chk("auto strobe", s + (m < 7), n_strobe);
            if (m < 7) begin
                chk("auto word", staged(), tw);
                rd_ok(dpcc_pkg::IDX_TW_UPD, 8'((m << 4) | 3));
            end
        end
        wr_ok(dpcc_pkg::IDX_TW_UPD, 8'h00);
    endtask : t_tw_auto

    task automatic t_bus_errors;
        wr(32'h00001274, 8'h00, 4'h1, dpcc_pkg::RESP_SLVERR);
        rd(32'h00001274, 8'h00, dpcc_pkg::RESP_SLVERR);
        wr(adr(dpcc_pkg::IDX_CLK_POL), 8'h04, 4'h0, dpcc_pkg::RESP_OKAY);
        chk("no write", 3'b011, {inv_clk, duty, xctl});
        rd_ok(dpcc_pkg::IDX_CLK_POL, 8'h03);
    endtask : t_bus_errors

    initial begin
        for (int i = 0; i < 6; i++) stg[i] = 8'h00;
        repeat (8) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        t_reset_vals();
        t_clock_regs();
        t_test_out();
        t_lane_interp();
        t_datapath();
        t_tw_manual();
        t_tw_auto();
        t_bus_errors();
        end_of_test();
    end
endmodule : datapath_clock_config_regs_tb_top
